// ---- logic/sleep_wake_controller.v ----
// sleep entry and wake-up control with interrupt flag and enable registers
// assumes a core on SYS_CLK_I that pulses SLEEP_EXEC_I and honours CPU_RUN_O
//
// Function
// - undervolt flag sets on selected edge directions
// - interrupt entry pushes only return address
// - sleep clears watchdog; watchdog runs in sleep
// - sleep clears power-down, sets time-out flag
// - processor clock stopped while asleep
// - pins hold their drive state in sleep
// - sleep removes analog supply; converter unusable unless option reference bit set
// - analog enable settings survive sleep unchanged
// - only time-out, power-down flags touched; POR wakes
// - reset pin, POR reset; others continue
// - pin-change and external pin wake device
// - sleep prefetches instruction at address plus one
// - wake needs own enable, not global enable
// - run prefetched instruction, then vector if enabled
// - watchdog cleared on every wake-up
// - pending enabled flag makes sleep a no-op
// - late interrupt: finish sleep, wake at once
// - unimplemented interrupt bits read zero
// - flags set regardless of enables
// - watchdog time-out in sleep wakes, no reset
// - about ten microseconds delay before execution
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_defines.vh"

module sleep_wake_controller (
  input  wire        SYS_CLK_I,      // system clock
  input  wire        RESET_I,        // async reset, active high
  input  wire [3:0]  REG_ADDR_I,     // register address
  input  wire [7:0]  REG_WDATA_I,    // write data
  input  wire        REG_WR_I,       // write strobe
  input  wire        REG_RD_I,       // read strobe
  output reg  [7:0]  REG_RDATA_O,    // read data, cycle after strobe
  input  wire        SLEEP_EXEC_I,   // core executes sleep, one pulse
  input  wire [12:0] SLEEP_PC_I,     // address of the sleep instruction
  input  wire        POR_EVENT_I,    // power-on reset event pin
  input  wire        EXT_RESET_PIN_I,// external reset pin, active high
  input  wire        WDT_TIMEOUT_I,  // watchdog time-out pulse
  input  wire        UNDERVOLT_I,    // input undervoltage level
  input  wire        EXT_IRQ_PIN_I,  // external interrupt pin level
  input  wire [7:0]  PIN_CHANGE_I,   // port pin levels for change detect
  input  wire [7:0]  PERIPH1_EV_I,   // peripheral group one event pulses
  input  wire [7:1]  PERIPH2_EV_I,   // peripheral group two event pulses
  input  wire        TMR0_EV_I,      // timer0 overflow pulse
  input  wire        IRQ_ENTRY_I,    // core takes the interrupt vector
  input  wire [12:0] CORE_PC_I,      // return address at interrupt entry
  input  wire [7:0]  PIN_OE_I,       // core pin drive enables
  input  wire [7:0]  PIN_OUT_I,      // core pin output levels
  input  wire [3:0]  ANALOG_EN_I,    // analog enables set by core
  output reg         CPU_RUN_O,      // processor clock enable
  output wire        ASLEEP_O,       // asleep indication
  output wire        ANALOG_SUPPLY_O,// analog supply on
  output wire [3:0]  ANALOG_EN_O,    // analog enables applied
  output wire        CONV_USABLE_O,  // converter usable
  output reg  [7:0]  PIN_OE_O,       // held pin drive enables
  output reg  [7:0]  PIN_OUT_O,      // held pin levels
  output reg         WDT_CLEAR_O,    // watchdog and prescaler clear pulse
  output wire        WDT_ENABLE_O,   // watchdog runs
  output wire        WDT_RESET_O,    // watchdog reset request pulse
  output reg         DEVICE_RESET_O, // device reset request pulse
  output reg  [12:0] PREFETCH_PC_O,  // prefetch address
  output reg         PREFETCH_O,     // prefetch strobe
  output reg         VECTOR_O,       // vector to interrupt routine pulse
  output reg         STACK_PUSH_O,   // push return address pulse
  output reg  [12:0] STACK_DATA_O    // return address pushed
);

  localparam [1:0] ST_RUN   = 2'h0;  // executing
  localparam [1:0] ST_SLEEP = 2'h1;  // clock stopped
  localparam [1:0] ST_WAIT  = 2'h2;  // wake delay
  localparam [1:0] ST_EXEC  = 2'h3;  // prefetched instruction

  reg [7:0]  intctl_q;     // interrupt_control
  reg [7:0]  option_q;     // option_settings
  reg [7:0]  peripheral_irq_enable_one_q;       // peripheral_irq_enable_one
  reg [7:0]  peripheral_irq_enable_two_q;       // peripheral_irq_enable_two
  reg [7:0]  peripheral_irq_flags_one_q;       // peripheral_irq_flags_one
  reg [7:0]  peripheral_irq_flags_two_q;       // peripheral_irq_flags_two
  reg [7:0]  pca_q;        // pin_change_enable_port_a
  reg [7:0]  pcb_q;        // pin_change_enable_port_b
  reg [7:0]  status_q;     // cpu_status
  reg [7:0]  ctrl_q;       // edge selects, watchdog and pin enables
  reg [1:0]  state_q;      // sleep state
  reg [13:0] delay_q;      // wake delay counter
  reg        vec_pend_q;   // vector after prefetched instruction
  reg [3:0]  analog_q;     // analog enables, kept across sleep

  // synchronisers for pin inputs
  reg [14:0] s1_q;         // first stage
  reg [14:0] s2_q;         // second stage
  reg [14:0] s3_q;         // previous sample for edges
  wire [14:0] raw = {EXT_RESET_PIN_I, POR_EVENT_I, EXT_IRQ_PIN_I, UNDERVOLT_I,
                     PIN_CHANGE_I, 3'h0};

  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s1_q <= 15'h0000;
      s2_q <= 15'h0000;
      s3_q <= 15'h0000;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire       uv_now  = s2_q[11];  // undervoltage level
  wire       uv_prev = s3_q[11];
  wire       ext_now = s2_q[12];
  wire       ext_prev= s3_q[12];
  wire       por_sync= s2_q[13];
  wire       rst_pin = s2_q[14];
  wire [7:0] pc_chg  = (s2_q[10:3] ^ s3_q[10:3]) & (pca_q | pcb_q);

  // edge events
  wire uv_ev  = (ctrl_q[`SW_CT_RISE] & uv_now & ~uv_prev) |
                (ctrl_q[`SW_CT_FALL] & ~uv_now & uv_prev);
  wire ext_ev = option_q[`SW_OPT_EDGE] ? (ext_now & ~ext_prev) : (~ext_now & ext_prev);
  wire pc_ev  = |pc_chg;

  // wake request: flag and individual enable, global enable ignored
  wire periph_pend = |(peripheral_irq_flags_one_q & peripheral_irq_enable_one_q) | |(peripheral_irq_flags_two_q & peripheral_irq_enable_two_q);
  wire wake_req = (intctl_q[`SW_IC_EXTE] & intctl_q[`SW_IC_EXTF]) |
                  (intctl_q[`SW_IC_PCE] & intctl_q[`SW_IC_PCF]) |
                  (intctl_q[`SW_IC_TMR0E] & intctl_q[`SW_IC_TMR0F]) |
                  (intctl_q[`SW_IC_PERIPHERAL_IRQ_ENABLE] & periph_pend);

  wire asleep    = (state_q == ST_SLEEP);
  wire wr        = REG_WR_I;
  wire sleep_go  = SLEEP_EXEC_I & (state_q == ST_RUN) & ~wake_req;
  wire wdt_wake  = asleep & WDT_TIMEOUT_I & ctrl_q[`SW_CT_WDTE];
  wire rst_wake  = (rst_pin & ctrl_q[`SW_CT_RSTE]) | por_sync;

  assign ASLEEP_O        = asleep;
  assign ANALOG_SUPPLY_O = ~asleep;
  assign ANALOG_EN_O     = analog_q;
  assign CONV_USABLE_O   = ~asleep | option_q[`SW_OPT_REF];
  assign WDT_ENABLE_O    = ctrl_q[`SW_CT_WDTE];
  assign WDT_RESET_O     = WDT_TIMEOUT_I & ctrl_q[`SW_CT_WDTE] & ~asleep;

  // sleep state machine
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q        <= ST_WAIT;
      delay_q        <= 14'h0000;
      CPU_RUN_O      <= 1'b0;
      WDT_CLEAR_O    <= 1'b0;
      DEVICE_RESET_O <= 1'b0;
      PREFETCH_O     <= 1'b0;
      PREFETCH_PC_O  <= 13'h0000;
      VECTOR_O       <= 1'b0;
      vec_pend_q     <= 1'b0;
    end else begin
      WDT_CLEAR_O    <= 1'b0;
      DEVICE_RESET_O <= 1'b0;
      PREFETCH_O     <= 1'b0;
      VECTOR_O       <= 1'b0;
      case (state_q)
        ST_RUN: begin
          CPU_RUN_O <= 1'b1;
          if (sleep_go) begin
            state_q       <= ST_SLEEP;
            CPU_RUN_O     <= 1'b0;
            WDT_CLEAR_O   <= 1'b1;
            PREFETCH_O    <= 1'b1;
            PREFETCH_PC_O <= SLEEP_PC_I + 13'h0001;
          end
        end
        ST_SLEEP: begin
          if (rst_wake) begin
            DEVICE_RESET_O <= 1'b1;
            WDT_CLEAR_O    <= 1'b1;
            state_q        <= ST_WAIT;
            delay_q        <= 14'h0000;
            vec_pend_q     <= 1'b0;
          end else if (wake_req | wdt_wake) begin
            WDT_CLEAR_O <= 1'b1;
            state_q     <= ST_WAIT;
            delay_q     <= 14'h0000;
            vec_pend_q  <= wake_req & intctl_q[`SW_IC_GIE];
          end
        end
        ST_WAIT: begin
          CPU_RUN_O <= 1'b0;
          if (delay_q == (`SW_WAKE_CYC - 1)) begin
            state_q   <= ST_EXEC;
            CPU_RUN_O <= 1'b1;
          end else begin
            delay_q <= delay_q + 14'h0001;
          end
        end
        ST_EXEC: begin
          // prefetched instruction runs this cycle, then vector
          VECTOR_O   <= vec_pend_q;
          vec_pend_q <= 1'b0;
          state_q    <= ST_RUN;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // pin hold and analog enables: frozen while asleep
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PIN_OE_O  <= 8'h00;
      PIN_OUT_O <= 8'h00;
      analog_q  <= 4'h0;
    end else if (!asleep && !sleep_go) begin
      PIN_OE_O  <= PIN_OE_I;
      PIN_OUT_O <= PIN_OUT_I;
      analog_q  <= ANALOG_EN_I;
    end
  end

  // interrupt entry: only the return address goes on the stack
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      STACK_PUSH_O <= 1'b0;
      STACK_DATA_O <= 13'h0000;
    end else begin
      STACK_PUSH_O <= IRQ_ENTRY_I;
      if (IRQ_ENTRY_I)
        STACK_DATA_O <= CORE_PC_I;
    end
  end

  // registers: writes, with hardware set winning over software clear
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      intctl_q <= `SW_ZERO8;
      option_q <= `SW_OPTION_RST;
      peripheral_irq_enable_one_q   <= `SW_ZERO8;
      peripheral_irq_enable_two_q   <= `SW_ZERO8;
      peripheral_irq_flags_one_q   <= `SW_ZERO8;
      peripheral_irq_flags_two_q   <= `SW_ZERO8;
      pca_q    <= `SW_ZERO8;
      pcb_q    <= `SW_ZERO8;
      status_q <= `SW_STATUS_RST;
      ctrl_q   <= `SW_CTRL_RST;
    end else begin
      if (wr && REG_ADDR_I == `SW_OFF_INTCTL)   intctl_q <= REG_WDATA_I;
      if (wr && REG_ADDR_I == `SW_OFF_OPTION)   option_q <= REG_WDATA_I;
      if (wr && REG_ADDR_I == `SW_OFF_PERIPHERAL_IRQ_ENABLE_ONE)     peripheral_irq_enable_one_q <= REG_WDATA_I & `SW_PERIPHERAL_IRQ_ENABLE_ONE_MASK;
      if (wr && REG_ADDR_I == `SW_OFF_PERIPHERAL_IRQ_ENABLE_TWO)     peripheral_irq_enable_two_q <= REG_WDATA_I & `SW_PERIPHERAL_IRQ_ENABLE_TWO_MASK;
      if (wr && REG_ADDR_I == `SW_OFF_PCA)      pca_q  <= REG_WDATA_I & `SW_PCA_MASK;
      if (wr && REG_ADDR_I == `SW_OFF_PCB)      pcb_q  <= REG_WDATA_I & `SW_PCB_MASK;
      if (wr && REG_ADDR_I == `SW_OFF_CTRL)     ctrl_q <= REG_WDATA_I & `SW_CTRL_MASK;
      // flags: write first, then events set on top
      peripheral_irq_flags_one_q <= ((wr && REG_ADDR_I == `SW_OFF_PERIPHERAL_IRQ_FLAGS_ONE) ? REG_WDATA_I : peripheral_irq_flags_one_q)
                & `SW_PERIPHERAL_IRQ_FLAGS_ONE_MASK | (PERIPH1_EV_I & `SW_PERIPHERAL_IRQ_FLAGS_ONE_MASK);
      peripheral_irq_flags_two_q <= ((wr && REG_ADDR_I == `SW_OFF_PERIPHERAL_IRQ_FLAGS_TWO) ? REG_WDATA_I : peripheral_irq_flags_two_q)
                & `SW_PERIPHERAL_IRQ_FLAGS_TWO_MASK | ({PERIPH2_EV_I, uv_ev} & `SW_PERIPHERAL_IRQ_FLAGS_TWO_MASK);
      intctl_q[`SW_IC_EXTF]  <= ((wr && REG_ADDR_I == `SW_OFF_INTCTL) ?
                                 REG_WDATA_I[`SW_IC_EXTF] : intctl_q[`SW_IC_EXTF]) | ext_ev;
      intctl_q[`SW_IC_PCF]   <= ((wr && REG_ADDR_I == `SW_OFF_INTCTL) ?
                                 REG_WDATA_I[`SW_IC_PCF] : intctl_q[`SW_IC_PCF]) | pc_ev;
      intctl_q[`SW_IC_TMR0F] <= ((wr && REG_ADDR_I == `SW_OFF_INTCTL) ?
                                 REG_WDATA_I[`SW_IC_TMR0F] : intctl_q[`SW_IC_TMR0F]) | TMR0_EV_I;
      // status: bits 7:5 and 2:0 writable, power flags by hardware
      if (wr && REG_ADDR_I == `SW_OFF_STATUS) begin
        status_q[7:5] <= REG_WDATA_I[7:5];
        status_q[2:0] <= REG_WDATA_I[2:0];
      end
      if (sleep_go) begin
        status_q[`SW_ST_PD] <= 1'b0;
        status_q[`SW_ST_TO] <= 1'b1;
      end else if (WDT_TIMEOUT_I && ctrl_q[`SW_CT_WDTE]) begin
        status_q[`SW_ST_TO] <= 1'b0;
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `SW_OFF_INTCTL: REG_RDATA_O <= intctl_q;
        `SW_OFF_OPTION: REG_RDATA_O <= option_q;
        `SW_OFF_PERIPHERAL_IRQ_ENABLE_ONE:   REG_RDATA_O <= peripheral_irq_enable_one_q;
        `SW_OFF_PERIPHERAL_IRQ_ENABLE_TWO:   REG_RDATA_O <= peripheral_irq_enable_two_q;
        `SW_OFF_PERIPHERAL_IRQ_FLAGS_ONE:   REG_RDATA_O <= peripheral_irq_flags_one_q;
        `SW_OFF_PERIPHERAL_IRQ_FLAGS_TWO:   REG_RDATA_O <= peripheral_irq_flags_two_q;
        `SW_OFF_PCA:    REG_RDATA_O <= pca_q;
        `SW_OFF_PCB:    REG_RDATA_O <= pcb_q;
        `SW_OFF_STATUS: REG_RDATA_O <= status_q;
        `SW_OFF_CTRL:   REG_RDATA_O <= ctrl_q;
        `SW_OFF_STATE:  REG_RDATA_O <= {5'h00, wake_req, state_q};
        default:        REG_RDATA_O <= 8'h00;
      endcase
    end else begin
      REG_RDATA_O <= 8'h00;
    end
  end

endmodule // sleep_wake_controller
`default_nettype wire

// ---- logic/sleep_wake_defines.vh ----
// constants for the sleep and wake controller: register offsets, field positions,
// reset values and timing counts; included by logic/sleep_wake_controller.v
`ifndef SLEEP_WAKE_DEFINES_VH
`define SLEEP_WAKE_DEFINES_VH

// register offsets on the plain register port
`define SW_OFF_INTCTL     4'h0
`define SW_OFF_OPTION     4'h1
`define SW_OFF_PERIPHERAL_IRQ_ENABLE_ONE       4'h2
`define SW_OFF_PERIPHERAL_IRQ_ENABLE_TWO       4'h3
`define SW_OFF_PERIPHERAL_IRQ_FLAGS_ONE       4'h4
`define SW_OFF_PERIPHERAL_IRQ_FLAGS_TWO       4'h5
`define SW_OFF_PCA        4'h6
`define SW_OFF_PCB        4'h7
`define SW_OFF_STATUS     4'h8
`define SW_OFF_CTRL       4'h9
`define SW_OFF_STATE      4'hA

// interrupt_control fields
`define SW_IC_GIE         7
`define SW_IC_PERIPHERAL_IRQ_ENABLE        6
`define SW_IC_TMR0E       5
`define SW_IC_EXTE        4
`define SW_IC_PCE         3
`define SW_IC_TMR0F       2
`define SW_IC_EXTF        1
`define SW_IC_PCF         0

// implemented-bit masks (others read zero)
`define SW_PERIPHERAL_IRQ_ENABLE_ONE_MASK      8'h3F
`define SW_PERIPHERAL_IRQ_FLAGS_ONE_MASK      8'h33
`define SW_PERIPHERAL_IRQ_ENABLE_TWO_MASK      8'hDF
`define SW_PERIPHERAL_IRQ_FLAGS_TWO_MASK      8'hDF
`define SW_PCA_MASK       8'hEF
`define SW_PCB_MASK       8'hF3

// flag positions
`define SW_PERIPHERAL_IRQ_FLAGS_TWO_UVLO      0
`define SW_ST_TO          4
`define SW_ST_PD          3

// option_settings fields
`define SW_OPT_EDGE       6
`define SW_OPT_REF        0

// writable bits of the control register
`define SW_CTRL_MASK      8'h0F

// control register fields
`define SW_CT_RISE        0
`define SW_CT_FALL        1
`define SW_CT_WDTE        2
`define SW_CT_RSTE        3

// reset values
`define SW_STATUS_RST     8'h18
`define SW_OPTION_RST     8'hFF
`define SW_ZERO8          8'h00
`define SW_CTRL_RST       8'h0E

// timing: wake delay in ns and its cycle count at 8 ns period (rounded up)
`define SW_WAKE_DELAY_NS  10000
`define SW_CLK_PERIOD_NS  8
`define SW_WAKE_CYC       ((`SW_WAKE_DELAY_NS + `SW_CLK_PERIOD_NS - 1) / `SW_CLK_PERIOD_NS)

`endif

// ---- verif/core_model.sv ----
// processor core stand-in: counts, executes sleep, takes vectors
// assumes the controller clock and reset
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic        clk_i,      // system clock
  input  wire logic        rst_i,      // async reset
  input  wire logic        run_i,      // core clock enable
  input  wire logic        go_i,       // bench asks for sleep
  input  wire logic        vector_i,   // vector request
  output var  logic        sleep_o,    // sleep executed
  output wire logic [12:0] sleep_pc_o, // its address
  output var  logic        entry_o,    // interrupt entry
  output wire logic [12:0] ret_pc_o    // return address
);
  logic [12:0] pc_q; // program counter
  assign sleep_pc_o = pc_q;
  assign ret_pc_o   = pc_q;
  // counts only while clocked; sleeps only when running
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_q    <= 13'h0000;
      sleep_o <= 1'h0;
      entry_o <= 1'h0;
    end else begin
      if (run_i) pc_q <= pc_q + 13'h0001;
      sleep_o <= go_i && run_i;
      entry_o <= vector_i;
    end
  end
endmodule // core_model
`default_nettype wire

// ---- verif/sleep_wake_checker_sva.sv ----
// port checker for sleep_wake_controller
// assumes one clock SYS_CLK_I and async active-high RESET_I
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_defines.vh"
module sleep_wake_checker (
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_I,
  input wire logic        SLEEP_EXEC_I,
  input wire logic [12:0] SLEEP_PC_I,
  input wire logic        POR_EVENT_I,
  input wire logic        WDT_TIMEOUT_I,
  input wire logic        IRQ_ENTRY_I,
  input wire logic [12:0] CORE_PC_I,
  input wire logic        CPU_RUN_O,
  input wire logic        ASLEEP_O,
  input wire logic        ANALOG_SUPPLY_O,
  input wire logic        CONV_USABLE_O,
  input wire logic [3:0]  ANALOG_EN_O,
  input wire logic [7:0]  PIN_OE_O,
  input wire logic [7:0]  PIN_OUT_O,
  input wire logic        WDT_CLEAR_O,
  input wire logic        WDT_ENABLE_O,
  input wire logic        WDT_RESET_O,
  input wire logic        DEVICE_RESET_O,
  input wire logic [12:0] PREFETCH_PC_O,
  input wire logic        PREFETCH_O,
  input wire logic        STACK_PUSH_O,
  input wire logic [12:0] STACK_DATA_O
);
  localparam int WAKE_N = `SW_WAKE_CYC; // wake delay in cycles
  logic        asleep_q; // asleep one cycle ago
  logic [11:0] wait_q;   // cycles since leaving sleep
  default clocking main_cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // counts the wake delay; a reset-type wake is not timed
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      asleep_q <= 1'h0;
      wait_q   <= 12'h000;
    end else begin
      asleep_q <= ASLEEP_O;
      if (DEVICE_RESET_O || CPU_RUN_O) wait_q <= 12'h000;
      else if (asleep_q && !ASLEEP_O) wait_q <= 12'h001;
      else if (wait_q != 12'h000) wait_q <= wait_q + 12'h001;
    end
  end
  // sleep request from a running core, then taken or refused
  sequence sleep_cmd_s; CPU_RUN_O && SLEEP_EXEC_I; endsequence
  sequence sleep_taken_s; sleep_cmd_s ##1 ASLEEP_O; endsequence
  sequence sleep_refused_s; sleep_cmd_s ##1 !ASLEEP_O; endsequence
  sleep_state_a: assert property (ASLEEP_O |-> !CPU_RUN_O && !ANALOG_SUPPLY_O)
    else $error("core clock or analog supply on while asleep");
  conv_awake_a: assert property (!ASLEEP_O |-> CONV_USABLE_O && ANALOG_SUPPLY_O)
    else $error("converter or analog supply off while awake");
  sleep_hold_a: assert property (ASLEEP_O && asleep_q |->
    $stable(PIN_OE_O) && $stable(PIN_OUT_O) && $stable(ANALOG_EN_O))
    else $error("pin or analog state moved in sleep");
  sleep_entry_a: assert property (sleep_taken_s |-> WDT_CLEAR_O && PREFETCH_O
    && PREFETCH_PC_O == 13'($past(SLEEP_PC_I) + 13'h0001))
    else $error("sleep entry without clear or prefetch");
  sleep_noop_a: assert property (sleep_refused_s |-> !WDT_CLEAR_O)
    else $error("refused sleep cleared watchdog");
  wake_clear_a: assert property ($fell(ASLEEP_O) |-> WDT_CLEAR_O)
    else $error("wake without watchdog clear");
  wake_delay_a: assert property (wait_q != 12'h000 |-> CPU_RUN_O == (int'(wait_q) == WAKE_N))
    else $error("core restarted at wrong cycle");
  wdt_wake_a: assert property (ASLEEP_O && WDT_TIMEOUT_I && WDT_ENABLE_O |->
    !WDT_RESET_O ##1 !ASLEEP_O && WDT_CLEAR_O && !DEVICE_RESET_O)
    else $error("watchdog in sleep did not wake plainly");
  por_wake_a: assert property (ASLEEP_O && POR_EVENT_I |-> ##[1:5] DEVICE_RESET_O)
    else $error("power-on event did not reset from sleep");
  stack_push_a: assert property (IRQ_ENTRY_I |=> STACK_PUSH_O
    && STACK_DATA_O == $past(CORE_PC_I))
    else $error("wrong return address pushed");
endmodule // sleep_wake_checker
bind sleep_wake_controller sleep_wake_checker i_chk (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .SLEEP_EXEC_I(SLEEP_EXEC_I),
  .SLEEP_PC_I(SLEEP_PC_I), .POR_EVENT_I(POR_EVENT_I), .WDT_TIMEOUT_I(WDT_TIMEOUT_I),
  .IRQ_ENTRY_I(IRQ_ENTRY_I), .CORE_PC_I(CORE_PC_I), .CPU_RUN_O(CPU_RUN_O),
  .ASLEEP_O(ASLEEP_O), .ANALOG_SUPPLY_O(ANALOG_SUPPLY_O), .ANALOG_EN_O(ANALOG_EN_O),
  .CONV_USABLE_O(CONV_USABLE_O),
  .PIN_OE_O(PIN_OE_O), .PIN_OUT_O(PIN_OUT_O), .WDT_CLEAR_O(WDT_CLEAR_O),
  .WDT_ENABLE_O(WDT_ENABLE_O), .WDT_RESET_O(WDT_RESET_O), .DEVICE_RESET_O(DEVICE_RESET_O),
  .PREFETCH_PC_O(PREFETCH_PC_O), .PREFETCH_O(PREFETCH_O), .STACK_PUSH_O(STACK_PUSH_O),
  .STACK_DATA_O(STACK_DATA_O));
`default_nettype wire

// ---- verif/sleep_wake_controller_bench.sv ----
// self-checking bench for sleep_wake_controller with core stand-in
// assumes defines, controller, checker and core model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_defines.vh"
module sleep_wake_controller_bench;
  logic       clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, go = 1'h0, rd_seen = 1'h0;
  logic       por = 1'h0, xrst = 1'h0, wdt = 1'h0, uv = 1'h0, ext = 1'h0;
  logic [3:0] addr = 4'h0, an_en = 4'h0;
  logic [7:0] wdata = 8'h00, pins = 8'h00, oe = 8'h00, out = 8'h00, rdata;
  logic       run, asleep, vec, dres, sl, ent;
  logic [12:0] spc, rpc;
  logic [7:0] exp_q[$];  // expected read data, oldest first
  logic [7:0] rst_v [0:9] = '{`SW_ZERO8, `SW_OPTION_RST, `SW_ZERO8, `SW_ZERO8, `SW_ZERO8,
    `SW_ZERO8, `SW_ZERO8, `SW_ZERO8, `SW_STATUS_RST, `SW_CTRL_RST};
  logic [7:0] mk [2:7] = '{`SW_PERIPHERAL_IRQ_ENABLE_ONE_MASK, `SW_PERIPHERAL_IRQ_ENABLE_TWO_MASK, `SW_PERIPHERAL_IRQ_FLAGS_ONE_MASK, `SW_PERIPHERAL_IRQ_FLAGS_TWO_MASK,
    `SW_PCA_MASK, `SW_PCB_MASK};
  int         errors = 0, checked = 0, vec_n = 0, rst_n = 0, n;
  sleep_wake_controller i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .SLEEP_EXEC_I(sl), .SLEEP_PC_I(spc), .POR_EVENT_I(por), .EXT_RESET_PIN_I(xrst),
    .WDT_TIMEOUT_I(wdt), .UNDERVOLT_I(uv), .EXT_IRQ_PIN_I(ext), .PIN_CHANGE_I(pins),
    .PERIPH1_EV_I(8'h00), .PERIPH2_EV_I(7'h00), .TMR0_EV_I(1'h0), .IRQ_ENTRY_I(ent),
    .CORE_PC_I(rpc), .PIN_OE_I(oe), .PIN_OUT_I(out), .ANALOG_EN_I(an_en),
    .CPU_RUN_O(run), .ASLEEP_O(asleep), .ANALOG_SUPPLY_O(), .ANALOG_EN_O(),
    .CONV_USABLE_O(), .PIN_OE_O(), .PIN_OUT_O(), .WDT_CLEAR_O(), .WDT_ENABLE_O(),
    .WDT_RESET_O(), .DEVICE_RESET_O(dres), .PREFETCH_PC_O(), .PREFETCH_O(),
    .VECTOR_O(vec), .STACK_PUSH_O(), .STACK_DATA_O());
  core_model i_core (.clk_i(clk), .rst_i(rst), .run_i(run), .go_i(go), .vector_i(vec),
    .sleep_o(sl), .sleep_pc_o(spc), .entry_o(ent), .ret_pc_o(rpc));
  // clock, random pin and analog levels, pulse counters, read monitor
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    oe <= 8'($urandom);
    out <= 8'($urandom);
    an_en <= 4'($urandom);
    rd_seen <= rd;
  end
  always @(negedge clk) begin
    if (vec === 1'h1) vec_n++;
    if (dres === 1'h1) rst_n++;
    if (rd_seen && exp_q.size() > 0) compare(rdata, exp_q.pop_front(), "register read");
  end
  task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'h0;
  endtask
  // bounded wait for the core clock, then let vector and entry pass
  task automatic wait_run;
    int cyc;
    cyc = 0;
    while (run !== 1'h1 && cyc < 2000) begin
      @(posedge clk);
      cyc++;
    end
    compare({7'h00, run}, 8'h01, "core running");
    repeat (4) @(posedge clk);
  endtask
  task automatic doze(input logic e);
    @(posedge clk);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    @(posedge clk);
    @(negedge clk);
    compare({7'h00, asleep}, {7'h00, e}, "asleep");
  endtask
  task automatic complete_run;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #300us;
    errors++;
    $display("wrong value at %0t: run did not finish", $time);
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(27351));
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    wait_run();
    for (int i = 0; i < 10; i++) rd_reg(4'(i), rst_v[i]);
    rd_reg(4'hB, 8'h00);
    for (int i = 2; i < 8; i++) begin
      wr_reg(4'(i), 8'hFF);
      rd_reg(4'(i), mk[i]);
      wr_reg(4'(i), 8'h00);
    end
    // undervolt edge selects, rising then falling
    for (int s = 0; s < 2; s++) begin
      wr_reg(`SW_OFF_CTRL, (s == 0) ? 8'h0D : 8'h0E);
      uv <= 1'h1;
      repeat (6) @(posedge clk);
      rd_reg(`SW_OFF_PERIPHERAL_IRQ_FLAGS_TWO, {7'h00, s == 0});
      wr_reg(`SW_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 8'h00);
      uv <= 1'h0;
      repeat (6) @(posedge clk);
      rd_reg(`SW_OFF_PERIPHERAL_IRQ_FLAGS_TWO, {7'h00, s == 1});
      wr_reg(`SW_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 8'h00);
    end
    wr_reg(`SW_OFF_INTCTL, 8'h12);
    doze(1'h0);
    rd_reg(`SW_OFF_STATUS, `SW_STATUS_RST);
    wr_reg(`SW_OFF_INTCTL, 8'h00);
    // pin-change wake with global enable off
    wr_reg(`SW_OFF_PCA, 8'h01);
    wr_reg(`SW_OFF_INTCTL, 8'h08);
    doze(1'h1);
    rd_reg(`SW_OFF_STATUS, 8'h10);
    n = vec_n;
    pins <= 8'h01;
    wait_run();
    compare(8'(vec_n - n), 8'h00, "vector without global enable");
    wr_reg(`SW_OFF_INTCTL, 8'h00);
    // external pin wake with global enable on
    wr_reg(`SW_OFF_INTCTL, 8'h90);
    doze(1'h1);
    ext <= 1'h1;
    wait_run();
    compare(8'(vec_n - n), 8'h01, "vector with global enable");
    ext <= 1'h0;
    wr_reg(`SW_OFF_INTCTL, 8'h00);
    // watchdog wake
    doze(1'h1);
    wdt <= 1'h1;
    @(posedge clk);
    wdt <= 1'h0;
    wait_run();
    rd_reg(`SW_OFF_STATUS, 8'h00);
    compare(8'(rst_n), 8'h00, "reset on watchdog wake");
    // reset pin then power-on event, each followed by a fresh reset
    for (int k = 0; k < 2; k++) begin
      doze(1'h1);
      if (k == 0) xrst <= 1'h1;
      else por <= 1'h1;
      repeat (8) @(posedge clk);
      xrst <= 1'h0;
      por <= 1'h0;
      compare(8'(rst_n), 8'(k + 1), "reset-type wake");
      rst <= 1'h1;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      wait_run();
    end
    complete_run();
  end
endmodule // sleep_wake_controller_bench
`default_nettype wire
